// *** hdl/pin_cfg_pkg.sv ***
// Purpose: shared constants for the shared pin configuration block
// Assumes: 32-bit register port, byte addresses
// Notes: none
package pin_cfg_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] IND_CFG_OFS = 12'h1BC;
  localparam logic [11:0] GEN_CFG_OFS = 12'h1E0;
  localparam logic [11:0] CTRL_OFS = 12'h1F0;
  localparam logic [11:0] INT_STS_OFS = 12'h1F4;
  localparam logic [11:0] INT_MASK_OFS = 12'h1F8;
  // ==========================================================
  // field positions
  localparam int FUNC_LSB = 8;
  localparam int EN_LSB = 0;
  localparam int CHSEL_LSB = 24;
  localparam int POL_LSB = 16;
  localparam int EVOE_LSB = 8;
  localparam int BUF_LSB = 0;
  localparam int DIR_LSB = 16;
  localparam int DATA_LSB = 0;
  localparam int OFF_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [2:0] CHSEL_RST = 3'h0;
  localparam logic [2:0] POL_RST = 3'h0;
  localparam logic [2:0] EVOE_RST = 3'h0;
  localparam logic [2:0] BUF_RST = 3'h0;
  // count of edges after release before the straps are loaded
  localparam logic [1:0] STRAP_CYC = 2'h2;
  // ==========================================================
  // activity timing
  localparam int ACT_MS = 80;
  localparam int CLK_MHZ = 200;
  localparam int ACT_CYC = ACT_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {act_idle, act_on, act_off} act_state_t;
endpackage

// *** hdl/activity_pulse.sv ***
// Purpose: stretches activity into an on pulse followed by an off hold
// Assumes: act is synchronous to clock
// Notes: on and off lengths equal the parameter
module activity_pulse #(
  parameter int unsigned HOLD_CYC = pin_cfg_pkg::ACT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic act,
  output logic pulse
);
  pin_cfg_pkg::act_state_t state_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pin_cfg_pkg::act_idle;
      cnt_r <= 32'h0;
    end else begin
      unique case (state_r)
        pin_cfg_pkg::act_idle: begin
          if (act) begin
            state_r <= pin_cfg_pkg::act_on;
            cnt_r <= 32'h0;
          end
        end
        pin_cfg_pkg::act_on: begin
          if (cnt_r == HOLD_CYC - 1) begin
            state_r <= pin_cfg_pkg::act_off;
            cnt_r <= 32'h0;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        pin_cfg_pkg::act_off: begin
          if (cnt_r == HOLD_CYC - 1) begin
            state_r <= pin_cfg_pkg::act_idle;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
      endcase
    end
  end

  assign pulse = (state_r == pin_cfg_pkg::act_on);
endmodule

// *** hdl/pin_config.sv ***
// Purpose: configuration and drive logic for three shared pins
// Assumes: pins and straps come from outside and are synchronised here
// Notes: link status inputs come from the port logic on this clock
// ==========================================================
// How it works
// - the function field picks each enabled pin's indication
// - an enable bit of 0 makes its pin general purpose, 1 an indicator
// - an indicator pin is open-drain or open-source, input and pull-up off
// - indicator polarity is the hard strap at reset, high means active low
// - a general purpose pin without event output follows data, direction and buffer only
// - function and enable fields reset from their strap inputs
// - channel select bit 0 picks channel A, 1 channel B, reset 000b
// - polarity bit 0 lets a low level raise the pin interrupt, 1 a high
// - the polarity bit sets the active level of clock events driven out
// - the polarity bit sets the active level of the timer clear input
// - event output enable bit 1 puts compare events on the pin, reset 000b
// - event output enable forces output over direction, keeps buffer
// - activity pulses active 80 ms then holds inactive at least 80 ms
// - the global off bit leaves open-drain indicators undriven
// - buffer bit 0 is open-drain driven low on clear data, 1 push-pull
module pin_config #(
  parameter int unsigned ACT_HOLD = pin_cfg_pkg::ACT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [2:0] indicator_function_strap,
  input wire logic [2:0] indicator_enable_strap,
  input wire logic [2:0] polarity_strap,
  input wire logic [2:0] pin_buffer_type,
  input wire logic [2:0] pin_direction,
  input wire logic [2:0] pin_data,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_input_enable,
  output logic [2:0] pin_pullup_enable,
  input wire logic event_a,
  input wire logic event_b,
  output logic [2:0] pin_level_event,
  output logic [2:0] timer_clear,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic activity,
  output logic irq
);
  // ==========================================================
  // synchronisers and strap capture
  logic [2:0] pin_s1_r, pin_s2_r;
  logic [8:0] strap_s1_r, strap_s2_r;
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  wire strap_load = !strap_done_r && strap_cnt_r == pin_cfg_pkg::STRAP_CYC;
  logic [2:0] pol_hard_r;
  logic [2:0] func_r, en_r, chsel_r, pol_r, evoe_r;
  logic off_r;
  logic [2:0] sts_r, mask_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      strap_s1_r <= 9'h000;
      strap_s2_r <= 9'h000;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      strap_s1_r <= {polarity_strap, indicator_enable_strap,
                     indicator_function_strap};
      strap_s2_r <= strap_s1_r;
    end
  end

  // straps settle in the second flop, then load once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_done_r <= strap_load;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pol_hard_r <= 3'h0;
    end else if (strap_load) begin
      pol_hard_r <= strap_s2_r[8:6];
    end
  end

  // ==========================================================
  // register writes
  wire wr_ind = wr && addr == pin_cfg_pkg::IND_CFG_OFS;
  wire wr_gen = wr && addr == pin_cfg_pkg::GEN_CFG_OFS;
  wire wr_ctl = wr && addr == pin_cfg_pkg::CTRL_OFS;
  wire wr_msk = wr && addr == pin_cfg_pkg::INT_MASK_OFS;
  wire rd_sts = rd && addr == pin_cfg_pkg::INT_STS_OFS;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      func_r <= 3'h0;
      en_r <= 3'h0;
    end else if (strap_load) begin
      func_r <= strap_s2_r[2:0];
      en_r <= strap_s2_r[5:3];
    end else if (wr_ind) begin
      func_r <= wdata[pin_cfg_pkg::FUNC_LSB +: 3];
      en_r <= wdata[pin_cfg_pkg::EN_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chsel_r <= pin_cfg_pkg::CHSEL_RST;
      pol_r <= pin_cfg_pkg::POL_RST;
      evoe_r <= pin_cfg_pkg::EVOE_RST;
    end else if (wr_gen) begin
      chsel_r <= wdata[pin_cfg_pkg::CHSEL_LSB +: 3];
      pol_r <= wdata[pin_cfg_pkg::POL_LSB +: 3];
      evoe_r <= wdata[pin_cfg_pkg::EVOE_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      off_r <= 1'b0;
      mask_r <= 3'h0;
    end else begin
      if (wr_ctl) begin
        off_r <= wdata[pin_cfg_pkg::OFF_BIT];
      end
      if (wr_msk) begin
        mask_r <= wdata[2:0];
      end
    end
  end

  // ==========================================================
  // level interrupt status, set wins over read clear
  wire [2:0] hit = ~(pin_s2_r ^ pol_r) & ~en_r & {3{strap_done_r}};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sts_r <= 3'h0;
    end else begin
      sts_r <= (rd_sts ? 3'h0 : sts_r) | hit;
    end
  end

  assign irq = |(sts_r & mask_r);
  assign timer_clear = ~(pin_s2_r ^ pol_r);
  assign pin_level_event = hit;

  // ==========================================================
  // read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= 32'h0;
      unique case (addr)
        pin_cfg_pkg::IND_CFG_OFS: begin
          rdata[pin_cfg_pkg::FUNC_LSB +: 3] <= func_r;
          rdata[pin_cfg_pkg::EN_LSB +: 3] <= en_r;
        end
        pin_cfg_pkg::GEN_CFG_OFS: begin
          rdata[pin_cfg_pkg::CHSEL_LSB +: 3] <= chsel_r;
          rdata[pin_cfg_pkg::POL_LSB +: 3] <= pol_r;
          rdata[pin_cfg_pkg::EVOE_LSB +: 3] <= evoe_r;
          rdata[pin_cfg_pkg::BUF_LSB +: 3] <= pin_buffer_type;
        end
        pin_cfg_pkg::CTRL_OFS: rdata[pin_cfg_pkg::OFF_BIT] <= off_r;
        pin_cfg_pkg::INT_STS_OFS: rdata[2:0] <= sts_r;
        pin_cfg_pkg::INT_MASK_OFS: rdata[2:0] <= mask_r;
        default: rdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // indication functions
  logic act_p, col_p;

  activity_pulse #(.HOLD_CYC(ACT_HOLD)) u_act (
    .clock(clock),
    .rst_n(rst_n),
    .act(activity),
    .pulse(act_p)
  );

  activity_pulse #(.HOLD_CYC(ACT_HOLD)) u_col (
    .clock(clock),
    .rst_n(rst_n),
    .act(collision && !full_duplex),
    .pulse(col_p)
  );

  wire act_ind = link_up && act_p;
  wire lnk_act = link_up && !act_p;
  wire fd_col = link_up && (full_duplex || col_p);
  wire l100 = link_up && speed_100;
  wire l10 = link_up && !speed_100;

  // per pin indication, true when active
  function automatic logic ind_sel(input logic [2:0] f, input int p);
    logic r;
    r = 1'b0;
    unique case (f)
      3'h0: r = (p == 2) ? lnk_act : (p == 1) ? fd_col : l100;
      3'h1: r = (p == 2) ? l100 && !act_p : (p == 1) ? fd_col :
                l10 && !act_p;
      3'h2: r = (p == 2) ? act_ind : (p == 1) ? link_up : l100;
      3'h3: r = (p == 2) ? act_ind : (p == 1) ? link_up : fd_col;
      3'h4: r = (p == 2) ? act_ind : (p == 1) ? l10 : l100;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // pin drive
  logic [2:0] out_nxt, oe_nxt;
  logic ev, on;

  always_comb begin
    out_nxt = 3'h0;
    oe_nxt = 3'h0;
    ev = 1'b0;
    on = 1'b0;
    for (int i = 0; i < 3; i++) begin
      ev = chsel_r[i] ? event_b : event_a;
      on = ind_sel(func_r, i) && !off_r;
      if (en_r[i]) begin
        // open-drain or open-source, active level opposite hard strap
        out_nxt[i] = !pol_hard_r[i];
        oe_nxt[i] = on;
      end else if (evoe_r[i]) begin
        out_nxt[i] = pol_r[i] ? ev : !ev;
        oe_nxt[i] = pin_buffer_type[i] || !out_nxt[i];
      end else begin
        out_nxt[i] = pin_data[i];
        oe_nxt[i] = pin_direction[i] &&
                    (pin_buffer_type[i] || !pin_data[i]);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
    end
  end

  assign pin_input_enable = ~en_r;
  assign pin_pullup_enable = ~en_r;

  // ==========================================================
  // checks
  property p_ind_float;
    @(posedge clock) disable iff (!rst_n)
      (strap_done_r && en_r[0] && off_r) |=> !pin_oe[0];
  endproperty
  a_ind_float: assert property (p_ind_float)
    else $error("disabled indicator driven");

  property p_evoe_force;
    @(posedge clock) disable iff (!rst_n)
      (!en_r[1] && evoe_r[1] && pin_buffer_type[1]) |=> pin_oe[1];
  endproperty
  a_evoe_force: assert property (p_evoe_force)
    else $error("event pin not forced out");

  property p_gp_od;
    @(posedge clock) disable iff (!rst_n)
      (!en_r[2] && !evoe_r[2] && pin_direction[2] && !pin_buffer_type[2]
       && pin_data[2]) |=> !pin_oe[2];
  endproperty
  a_gp_od: assert property (p_gp_od)
    else $error("open drain drove high");

  property p_no_pull;
    @(posedge clock) disable iff (!rst_n)
      en_r[0] |-> !pin_input_enable[0] && !pin_pullup_enable[0];
  endproperty
  a_no_pull: assert property (p_no_pull)
    else $error("indicator input buffer on");

  property p_resv;
    @(posedge clock) disable iff (!rst_n)
      rd |=> rdata[31:27] == 5'h0 && rdata[7:3] == 5'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits not zero");

  property p_irq_lvl;
    @(posedge clock) disable iff (!rst_n)
      (strap_done_r && !en_r[0] && pin_s2_r[0] == pol_r[0]) |=> sts_r[0];
  endproperty
  a_irq_lvl: assert property (p_irq_lvl)
    else $error("level did not set status");

  property p_pol_hold;
    @(posedge clock) disable iff (!rst_n)
      strap_done_r |=> $stable(pol_hard_r);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("strap polarity changed");

  property p_ev_lvl;
    @(posedge clock) disable iff (!rst_n)
      (!en_r[0] && evoe_r[0] && !chsel_r[0] && event_a)
        |=> pin_out[0] == $past(pol_r[0]);
  endproperty
  a_ev_lvl: assert property (p_ev_lvl)
    else $error("event level wrong");

  sequence s_strap_wait;
    !strap_done_r && strap_cnt_r == 2'h1 ##1 strap_load;
  endsequence
  property p_strap_fields;
    @(posedge clock) disable iff (!rst_n)
      s_strap_wait |=> {en_r, func_r} == $past(strap_s2_r[5:0]);
  endproperty
  a_strap_fields: assert property (p_strap_fields)
    else $error("strap defaults not loaded");
endmodule

// *** testbench/pin_board.sv ***
// Purpose: board circuitry on the three shared pins
// Assumes: every pin has a pull-up resistor
// Notes: an outside source may drive a pin the block leaves free
module pin_board (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_level,
  input wire logic [2:0] ext_oe,
  output logic [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // wire level
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (pin_oe[p]) begin
        pin_level[p] = pin_out[p];
      end else if (ext_oe[p]) begin
        pin_level[p] = ext_level[p];
      end else begin
        pin_level[p] = 1'b1;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the shared pin block
// Assumes: hold count shortened to 8 cycles
// Notes: register model kept in integers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  localparam logic [11:0] IND = pin_cfg_pkg::IND_CFG_OFS;
  localparam logic [11:0] GEN = pin_cfg_pkg::GEN_CFG_OFS;
  localparam logic [11:0] STS = pin_cfg_pkg::INT_STS_OFS;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] fs = 3'h0, es = 3'h0, ps = 3'h0, bt = 3'h0, dir = 3'h0;
  logic [2:0] dat = 3'h0, xl = 3'h0, xoe = 3'h0, eo, eoe;
  logic [2:0] lvl, pout, poe, pie, ppe, plev, tclr;
  logic ea = 1'b0, eb = 1'b0, link = 1'b0, spd = 1'b0, act = 1'b0;
  logic fdx = 1'b0, col = 1'b0;
  logic irq, ev;
  logic [31:0] w;
  int error_cnt = 0;
  int compares = 0;
  int n, m;
  always #2.5 clock = ~clock;
  pin_board board (.pin_out(pout), .pin_oe(poe), .ext_level(xl),
    .ext_oe(xoe), .pin_level(lvl));
  pin_config #(.ACT_HOLD(HOLD)) dut (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .indicator_function_strap(fs), .indicator_enable_strap(es),
    .polarity_strap(ps), .pin_buffer_type(bt), .pin_direction(dir),
    .pin_data(dat), .pin_in(lvl), .pin_out(pout), .pin_oe(poe),
    .pin_input_enable(pie), .pin_pullup_enable(ppe), .event_a(ea),
    .event_b(eb), .pin_level_event(plev), .timer_clear(tclr),
    .link_up(link), .speed_100(spd), .full_duplex(fdx),
    .collision(col), .activity(act), .irq(irq));
  // ==========================================================
  // tasks
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hF1A6EE3D));
    fs = 3'($urandom);
    es = 3'($urandom);
    ps = 3'($urandom);
    bt = 3'($urandom);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    settle(2);
    rchk(IND, {21'h0, fs, 5'h0, es});
    rchk(GEN, {29'h0, bt});
    rchk(12'h100, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      wreg(IND, w);
      rchk(IND, w & 32'h0000_0707);
      wreg(GEN, w);
      rchk(GEN, (w & 32'h0707_0700) | {29'h0, bt});
    end
    link <= 1'b1;
    spd <= 1'b1;
    wreg(GEN, 32'h0);
    wreg(IND, 32'h0000_0001);
    settle(3);
    chk(32'(poe[0]), 32'h1);
    chk(32'(pout[0]), 32'(!ps[0]));
    chk(32'(pie), 32'h6);
    chk(32'(ppe), 32'h6);
    wreg(pin_cfg_pkg::CTRL_OFS, 32'h1);
    settle(3);
    chk(32'(poe[0]), 32'h0);
    wreg(pin_cfg_pkg::CTRL_OFS, 32'h0);
    spd <= 1'b0;
    settle(3);
    chk(32'(poe[0]), 32'h0);
    fdx <= 1'b1;
    wreg(IND, 32'h0000_0305);
    settle(3);
    chk(32'(poe), 32'h1);
    fdx <= 1'b0;
    settle(3);
    chk(32'(poe), 32'h0);
    act <= 1'b1;
    col <= 1'b1;
    @(posedge clock);
    act <= 1'b0;
    col <= 1'b0;
    n = 0;
    m = 0;
    for (int i = 0; i < 40; i++) begin
      settle(1);
      if (poe[2] === 1'b1) n++;
      if (poe[0] === 1'b1) m++;
      act <= (i == 10);
    end
    chk(n, HOLD);
    chk(m, HOLD);
    wreg(IND, 32'h0);
    w = ($urandom & 32'h0707_0000) | 32'h0000_0700;
    wreg(GEN, w);
    for (int i = 0; i < 8; i++) begin
      ea <= i[0];
      eb <= i[1];
      bt <= {3{i[2]}};
      settle(3);
      for (int p = 0; p < 3; p++) begin
        ev = w[24+p] ? eb : ea;
        eo[p] = w[16+p] ? ev : ~ev;
        eoe[p] = i[2] | ~eo[p];
      end
      chk(32'(pout), 32'(eo));
      chk(32'(poe), 32'(eoe));
    end
    wreg(GEN, 32'h0);
    for (int i = 0; i < 6; i++) begin
      dat <= 3'($urandom);
      dir <= 3'($urandom);
      bt <= 3'($urandom);
      settle(3);
      chk(32'(pout), 32'(dat));
      chk(32'(poe), 32'(dir & (bt | ~dat)));
    end
    dir <= 3'h0;
    xoe <= 3'h7;
    xl <= 3'h7;
    wreg(GEN, 32'h0001_0000);
    settle(4);
    @(posedge clock);
    addr <= STS;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    rchk(STS, 32'h1);
    wreg(pin_cfg_pkg::INT_MASK_OFS, 32'h7);
    settle(1);
    chk(32'(plev), 32'h1);
    chk(32'(tclr), 32'h1);
    chk(32'(irq), 32'h1);
    xl <= 3'h6;
    settle(4);
    rchk(STS, 32'h1);
    settle(1);
    chk(32'(irq), 32'h0);
    rchk(STS, 32'h0);
    xl <= 3'h7;
    wreg(pin_cfg_pkg::INT_MASK_OFS, 32'h0);
    settle(4);
    chk(32'(irq), 32'h0);
    fs <= 3'($urandom);
    es <= 3'($urandom);
    ps <= 3'($urandom);
    rst_n <= 1'b0;
    settle(4);
    rst_n <= 1'b1;
    settle(2);
    rchk(IND, {21'h0, fs, 5'h0, es});
    rchk(GEN, {29'h0, bt});
    wreg(IND, 32'h0000_0202);
    settle(3);
    chk(32'(poe[1]), 32'h1);
    chk(32'(pout[1]), 32'(!ps[1]));
    end_of_test();
  end
endmodule
